// ---- logic/lcr_defs.vh ----
// register indices, field positions, reset values and timing counts for lane config
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define LCR_IDX_SIG 4'h0
`define LCR_IDX_LOAD 4'h1
`define LCR_IDX_LBDE 4'h2
`define LCR_IDX_INDIS 4'h3
`define LCR_IDX_OUTDIS 4'h4
`define LCR_IDX_CRST 4'h5
`define LCR_IDX_PWR 4'h6
`define LCR_IDX_RXDE 4'h7
`define LCR_IDX_EOC_A 4'h8
`define LCR_IDX_EOC_B 4'h9
`define LCR_IDX_RSVD 4'hA

// ==========================================================================
// field positions
`define LCR_LBDE_LB_N 0
`define LCR_LBDE_HB_A 1
`define LCR_LBDE_HB_B 2
`define LCR_CRST_BIT 0
`define LCR_PWR_BIT 0
`define LCR_RXDE_A 0
`define LCR_RXDE_B 1
`define LCR_EOC_EQ_LSB 0
`define LCR_EOC_SW_LSB 3
`define LCR_EOC_DE_LSB 5

// ==========================================================================
// reset values and timing
`define LCR_RDATA_RST 32'h00000000
`define LCR_CNT_RST 16'h0000
`define LCR_DETECT_CYCLES 16'h03E8

`endif

// ---- logic/lcr_lane_cfg_rxdet.v ----
// lane configuration registers, strap capture and receiver-detect sequencing
`timescale 1ns/1ps
`include "lcr_defs.vh"
module lcr_lane_cfg_rxdet #(
   parameter [15:0] DETECT_CYCLES = `LCR_DETECT_CYCLES
) (
   input wire MCLK,
   input wire NRST,
   input wire CE,
   input wire CFG_PIN_SEL,
   input wire LOOPBACK_N,
   input wire CHAN_RESET_N,
   input wire POWER_DOWN_N,
   input wire RXD_EN_A,
   input wire RXD_EN_B,
   input wire HALFBIT_SEL_GRP_A,
   input wire HALFBIT_SEL_GRP_B,
   input wire [2:0] EQ_STRAP_A,
   input wire [2:0] EQ_STRAP_B,
   input wire [2:0] DEEMPH_STRAP_A,
   input wire [2:0] DEEMPH_STRAP_B,
   input wire [1:0] SWING_STRAP_A,
   input wire [1:0] SWING_STRAP_B,
   input wire [7:0] SIG_ABOVE,
   input wire [7:0] LOAD_SENSE,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output wire [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   output wire [2:0] EQ_A,
   output wire [2:0] EQ_B,
   output wire [1:0] SWING_A,
   output wire [1:0] SWING_B,
   output wire [2:0] DEEMPH_A,
   output wire [2:0] DEEMPH_B,
   output wire HALFBIT_A,
   output wire HALFBIT_B,
   output wire LOOPBACK_OUT_N,
   output wire SIG_PRESENT_A0,
   output wire SIG_PRESENT_B0,
   output wire LOAD_PRESENT_A0,
   output wire LOAD_PRESENT_B0,
   output wire [7:0] IN_TERM_50,
   output wire [7:0] OUT_DRIVE_50,
   output wire [7:0] OUT_PULLUP_2K
);

   localparam [1:0] ST_RESET = 2'b00;
   localparam [1:0] ST_WAIT = 2'b01;
   localparam [1:0] ST_DONE = 2'b10;
   localparam [1:0] ST_BYP = 2'b11;

   // ==========================================================================
   // reset release
   reg rst_s1_q;
   reg rst_n_q;

   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else if (CE) begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ==========================================================================
   // configuration registers
   reg cap_done_q;
   reg lb_n_q;
   reg [1:0] hb_q;
   reg crst_n_q;
   reg pwr_n_q;
   reg [1:0] rxd_q;
   reg [7:0] indis_q;
   reg [7:0] outdis_q;
   reg [5:0] eq_q;
   reg [3:0] sw_q;
   reg [5:0] de_q;
   reg [7:0] sig_q;

   // bus bookkeeping
   reg wr_pend_q;
   reg rd_pend_q;
   reg map_q;
   reg [3:0] idx_q;
   reg hready_q;
   reg [31:0] hrdata_q;

   wire addr_ph = HSEL & HREADY & HTRANS[1];
   // live pin, never latched, so a change takes effect on the next write
   wire wr_ok = ~CFG_PIN_SEL & cap_done_q;
   wire wr_now = wr_pend_q & map_q & wr_ok;
   wire [7:0] wb = HWDATA[7:0];

   // effective channel controls: live pin and register must both allow
   wire crst_n = CHAN_RESET_N & crst_n_q;
   wire pwr_n = POWER_DOWN_N & pwr_n_q;

   wire [7:0] load_all;

   function [7:0] rd_byte;
      input [3:0] idx;
      begin
         if (idx == `LCR_IDX_SIG) begin
            rd_byte = sig_q;
         end else if (idx == `LCR_IDX_LOAD) begin
            rd_byte = load_all;
         end else if (idx == `LCR_IDX_LBDE) begin
            rd_byte = {5'h00, hb_q, lb_n_q};
         end else if (idx == `LCR_IDX_INDIS) begin
            rd_byte = indis_q;
         end else if (idx == `LCR_IDX_OUTDIS) begin
            rd_byte = outdis_q;
         end else if (idx == `LCR_IDX_CRST) begin
            rd_byte = {7'h00, crst_n_q};
         end else if (idx == `LCR_IDX_PWR) begin
            rd_byte = {7'h00, pwr_n_q};
         end else if (idx == `LCR_IDX_RXDE) begin
            rd_byte = {6'h00, rxd_q};
         end else if (idx == `LCR_IDX_EOC_A) begin
            rd_byte = {de_q[2:0], sw_q[1:0], eq_q[2:0]};
         end else if (idx == `LCR_IDX_EOC_B) begin
            rd_byte = {de_q[5:3], sw_q[3:2], eq_q[5:3]};
         end else begin
            rd_byte = 8'h00;
         end
      end
   endfunction

   // ==========================================================================
   // bus slave: writes are zero-wait, reads take one wait state
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         map_q <= 1'b0;
         idx_q <= 4'h0;
         hready_q <= 1'b1;
         hrdata_q <= `LCR_RDATA_RST;
      end else if (CE) begin
         wr_pend_q <= addr_ph & HWRITE;
         rd_pend_q <= addr_ph & ~HWRITE;
         hready_q <= ~(addr_ph & ~HWRITE);
         if (addr_ph) begin
            idx_q <= HADDR[5:2];
            map_q <= (HADDR[31:6] == 26'h0000000) && (HADDR[1:0] == 2'h0);
         end
         // sampled a cycle late so a write just before the read is seen
         if (rd_pend_q) begin
            hrdata_q <= map_q ? {24'h000000, rd_byte(idx_q)} : `LCR_RDATA_RST;
         end
      end
   end

   // ==========================================================================
   // strap capture and register writes
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cap_done_q <= 1'b0;
         lb_n_q <= 1'b1;
         hb_q <= 2'h3;
         crst_n_q <= 1'b0;
         pwr_n_q <= 1'b0;
         rxd_q <= 2'h0;
         indis_q <= 8'h00;
         outdis_q <= 8'h00;
         eq_q <= 6'h00;
         sw_q <= 4'h0;
         de_q <= 6'h00;
         sig_q <= 8'h00;
      end else if (CE) begin
         sig_q <= SIG_ABOVE;
         if (!cap_done_q) begin
            // one capture right after reset release
            cap_done_q <= 1'b1;
            lb_n_q <= LOOPBACK_N;
            hb_q <= {HALFBIT_SEL_GRP_B, HALFBIT_SEL_GRP_A};
            crst_n_q <= 1'b1;
            pwr_n_q <= 1'b1;
            rxd_q <= {RXD_EN_B, RXD_EN_A};
            eq_q <= {EQ_STRAP_B, EQ_STRAP_A};
            sw_q <= {SWING_STRAP_B, SWING_STRAP_A};
            de_q <= {DEEMPH_STRAP_B, DEEMPH_STRAP_A};
         end else if (wr_now) begin
            if (idx_q == `LCR_IDX_LBDE) begin
               lb_n_q <= wb[`LCR_LBDE_LB_N];
               hb_q[0] <= wb[`LCR_LBDE_HB_A];
               hb_q[1] <= wb[`LCR_LBDE_HB_B];
            end else if (idx_q == `LCR_IDX_INDIS) begin
               indis_q <= wb;
            end else if (idx_q == `LCR_IDX_OUTDIS) begin
               outdis_q <= wb;
            end else if (idx_q == `LCR_IDX_CRST) begin
               crst_n_q <= wb[`LCR_CRST_BIT];
            end else if (idx_q == `LCR_IDX_PWR) begin
               pwr_n_q <= wb[`LCR_PWR_BIT];
            end else if (idx_q == `LCR_IDX_RXDE) begin
               rxd_q <= wb[1:0];
            end else if (idx_q == `LCR_IDX_EOC_A) begin
               eq_q[2:0] <= wb[`LCR_EOC_EQ_LSB +: 3];
               sw_q[1:0] <= wb[`LCR_EOC_SW_LSB +: 2];
               de_q[2:0] <= wb[`LCR_EOC_DE_LSB +: 3];
            end else if (idx_q == `LCR_IDX_EOC_B) begin
               eq_q[5:3] <= wb[`LCR_EOC_EQ_LSB +: 3];
               sw_q[3:2] <= wb[`LCR_EOC_SW_LSB +: 2];
               de_q[5:3] <= wb[`LCR_EOC_DE_LSB +: 3];
            end
         end
      end
   end

   // ==========================================================================
   // per-channel termination: {in 50-Ohm, out 50-Ohm driving, out 2K pull-up}
   function [2:0] io_mode;
      input pwr;
      input rxd;
      input rst_n;
      input done;
      input load;
      input sig;
      input dis;
      begin
         if (!pwr) begin
            io_mode = 3'h0;
         end else if (!rst_n || dis) begin
            io_mode = 3'h1;
         end else if (rxd && !(done && load)) begin
            io_mode = 3'h1;
         end else if (sig) begin
            io_mode = 3'h6;
         end else begin
            // squelch: driver off, output pulled to supply
            io_mode = 3'h5;
         end
      end
   endfunction

   // ==========================================================================
   // receiver-detect sequencer, one per group
   genvar g;
   genvar c;
   generate
      for (g = 0; g < 2; g = g + 1) begin : grp
         reg [1:0] st_q;
         reg [15:0] cnt_q;
         reg [3:0] load_q;
         reg [3:0] in_q;
         reg [3:0] drv_q;
         reg [3:0] pu_q;
         wire rxd = rxd_q[g];
         wire done = (st_q == ST_DONE);

         always @(posedge MCLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
               st_q <= ST_RESET;
               cnt_q <= `LCR_CNT_RST;
               load_q <= 4'h0;
            end else if (CE) begin
               if (!cap_done_q || !pwr_n || !crst_n) begin
                  st_q <= ST_RESET;
                  cnt_q <= `LCR_CNT_RST;
                  load_q <= 4'h0;
               end else if (!rxd) begin
                  st_q <= ST_BYP;
                  load_q <= 4'h0;
               end else begin
                  case (st_q)
                     ST_RESET: begin
                        // leaving here follows release of channel reset, power down or the strap capture
                        st_q <= ST_WAIT;
                        cnt_q <= `LCR_CNT_RST;
                     end
                     ST_WAIT: begin
                        if (cnt_q == DETECT_CYCLES - 16'h0001) begin
                           load_q <= LOAD_SENSE[g*4 +: 4];
                           st_q <= ST_DONE;
                        end else begin
                           cnt_q <= cnt_q + 16'h0001;
                        end
                     end
                     ST_DONE: begin
                        st_q <= ST_DONE;
                     end
                     default: begin
                        st_q <= ST_WAIT;
                        cnt_q <= `LCR_CNT_RST;
                     end
                  endcase
               end
            end
         end

         for (c = 0; c < 4; c = c + 1) begin : ch
            wire [2:0] m = io_mode(pwr_n, rxd, crst_n, done, load_q[c],
                                   sig_q[g*4+c], outdis_q[g*4+c]);
            always @(posedge MCLK or negedge rst_n_q) begin
               if (!rst_n_q) begin
                  in_q[c] <= 1'b0;
                  drv_q[c] <= 1'b0;
                  pu_q[c] <= 1'b0;
               end else if (CE) begin
                  in_q[c] <= m[2] & ~indis_q[g*4+c];
                  drv_q[c] <= m[1];
                  pu_q[c] <= m[0];
               end
            end
         end
      end
   endgenerate

   assign load_all = {grp[1].load_q, grp[0].load_q};

   // ==========================================================================
   // outputs, each straight from a flip-flop except HRESP, which is tied low
   reg sig_a0_q;
   reg sig_b0_q;
   reg load_a0_q;
   reg load_b0_q;

   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sig_a0_q <= 1'b0;
         sig_b0_q <= 1'b0;
         load_a0_q <= 1'b0;
         load_b0_q <= 1'b0;
      end else if (CE) begin
         sig_a0_q <= SIG_ABOVE[0];
         sig_b0_q <= SIG_ABOVE[4];
         // result is only shown once the cycle has concluded
         load_a0_q <= grp[0].load_q[0] & (grp[0].st_q == ST_DONE);
         load_b0_q <= grp[1].load_q[0] & (grp[1].st_q == ST_DONE);
      end
   end

   assign HRDATA = hrdata_q;
   assign HREADYOUT = hready_q;
   assign HRESP = 1'b0;
   // codes forwarded unchanged; no rate-dependent adjustment exists
   assign EQ_A = eq_q[2:0];
   assign EQ_B = eq_q[5:3];
   assign SWING_A = sw_q[1:0];
   assign SWING_B = sw_q[3:2];
   assign DEEMPH_A = de_q[2:0];
   assign DEEMPH_B = de_q[5:3];
   assign HALFBIT_A = hb_q[0];
   assign HALFBIT_B = hb_q[1];
   assign LOOPBACK_OUT_N = lb_n_q;
   assign SIG_PRESENT_A0 = sig_a0_q;
   assign SIG_PRESENT_B0 = sig_b0_q;
   assign LOAD_PRESENT_A0 = load_a0_q;
   assign LOAD_PRESENT_B0 = load_b0_q;
   assign IN_TERM_50 = {grp[1].in_q, grp[0].in_q};
   assign OUT_DRIVE_50 = {grp[1].drv_q, grp[0].drv_q};
   assign OUT_PULLUP_2K = {grp[1].pu_q, grp[0].pu_q};

endmodule // lcr_lane_cfg_rxdet

// ---- verification/lcr_line_model.sv ----
// far-side line model: a load on each channel output seen through the detect pull-up
`timescale 1ns/1ps
module lcr_line_model (
   input wire [7:0] load_mask,
   input wire [7:0] pullup_on,
   output wire [7:0] load_sense
);
   // a released pin shows the opposite level so a stale value never passes
   assign load_sense = (pullup_on & load_mask) | (~pullup_on & ~load_mask);
endmodule // lcr_line_model

// ---- verification/lcr_checker.sv ----
// concurrent assertions on the ports of the lane configuration block
`timescale 1ns/1ps
module lcr_checker #(
   parameter [15:0] DETECT_CYCLES = 16'h03E8
) (
   input wire MCLK,
   input wire NRST,
   input wire CFG_PIN_SEL,
   input wire CHAN_RESET_N,
   input wire POWER_DOWN_N,
   input wire RXD_EN_A,
   input wire RXD_EN_B,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire HREADY,
   input wire HREADYOUT,
   input wire HRESP,
   input wire [2:0] EQ_A,
   input wire [7:0] SIG_ABOVE,
   input wire [7:0] LOAD_SENSE,
   input wire SIG_PRESENT_A0,
   input wire SIG_PRESENT_B0,
   input wire LOAD_PRESENT_A0,
   input wire LOAD_PRESENT_B0,
   input wire [7:0] IN_TERM_50,
   input wire [7:0] OUT_DRIVE_50,
   input wire [7:0] OUT_PULLUP_2K
);
   localparam int DWIN = DETECT_CYCLES + 6;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   // ====
   // settle counter: skips the reset synchroniser and strap capture
   reg [2:0] up_q;
   wire rdy = (up_q == 3'h7);
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) up_q <= 3'h0;
      else if (!rdy) up_q <= up_q + 3'h1;
   end
   // ====
   // assertions
   a_sel_locks_cfg: assert property (rdy && $past(CFG_PIN_SEL) |-> $stable(EQ_A))
      else $error("eq code changed while straps own the config");
   a_resp_always_okay: assert property (HRESP == 1'b0)
      else $error("bus response not okay");
   a_read_one_wait: assert property (HREADY && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   a_sig_one_late: assert property (rdy |-> {SIG_PRESENT_A0, SIG_PRESENT_B0} ==
      {$past(SIG_ABOVE[0]), $past(SIG_ABOVE[4])})
      else $error("signal present does not follow input");
   a_pdown_all_off: assert property ((rdy && !POWER_DOWN_N) [*3] |->
      {IN_TERM_50, OUT_DRIVE_50, OUT_PULLUP_2K} == 24'h000000)
      else $error("termination active in power down");
   a_reset_clears_load: assert property (rdy && !CHAN_RESET_N |-> ##2
      !LOAD_PRESENT_A0 && !LOAD_PRESENT_B0)
      else $error("load present held through channel reset");
   a_wait_before_load: assert property (rdy && $rose(CHAN_RESET_N) && RXD_EN_B && POWER_DOWN_N
      |-> ##2 (OUT_PULLUP_2K[4] && !LOAD_PRESENT_B0) [*2])
      else $error("detect wait skipped");
   a_load_in_time: assert property (rdy && $rose(CHAN_RESET_N) && RXD_EN_B && POWER_DOWN_N
      && LOAD_SENSE[4] |-> ##[1:DWIN] LOAD_PRESENT_B0)
      else $error("detect cycle did not finish in time");
   a_bypass_in_term: assert property ((rdy && !RXD_EN_A && POWER_DOWN_N && CHAN_RESET_N) [*3]
      |-> IN_TERM_50[3:0] == 4'hF)
      else $error("bypass lacks input termination");
endmodule // lcr_checker

// ---- verification/lcr_lane_cfg_rxdet_test.sv ----
// self-checking bench for the lane configuration and receiver-detect block
`timescale 1ns/1ps
module lcr_lane_cfg_rxdet_test;
   // ====
   // straps: loopback_n, half-bit A/B, eq A/B, de-emph A/B, swing A/B
   localparam [18:0] ST0 = {1'b1, 1'b1, 1'b0, 3'h5, 3'h2, 3'h3, 3'h6, 2'h1, 2'h2};
   reg mclk = 1'b0, nrst = 1'b0, sel = 1'b1, crst_n = 1'b1, pd_n = 1'b1;
   reg rxa = 1'b1, rxb = 1'b1, hwrite = 1'b0;
   reg [1:0] htrans = 2'h0;
   reg [7:0] sig = 8'h00, mask = 8'h0F;
   reg [18:0] st = ST0;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   wire [31:0] hrdata;
   wire hro, hresp, sp_a, sp_b, lp_a, lp_b;
   wire [18:0] cfg;
   wire [7:0] lsense, in50, drv50, pu2k;
   integer n_fail = 0, num_checks = 0, cyc = 0, i;
   always #25 mclk = ~mclk;
   lcr_line_model lcr_line_model_i (.load_mask(mask), .pullup_on(pu2k), .load_sense(lsense));
   lcr_lane_cfg_rxdet #(.DETECT_CYCLES(16'h0004)) lcr_lane_cfg_rxdet_i (
      .MCLK(mclk), .NRST(nrst), .CE(1'b1), .CFG_PIN_SEL(sel), .LOOPBACK_N(st[18]),
      .CHAN_RESET_N(crst_n), .POWER_DOWN_N(pd_n), .RXD_EN_A(rxa), .RXD_EN_B(rxb),
      .HALFBIT_SEL_GRP_A(st[17]), .HALFBIT_SEL_GRP_B(st[16]), .EQ_STRAP_A(st[15:13]),
      .EQ_STRAP_B(st[12:10]), .DEEMPH_STRAP_A(st[9:7]), .DEEMPH_STRAP_B(st[6:4]),
      .SWING_STRAP_A(st[3:2]), .SWING_STRAP_B(st[1:0]), .SIG_ABOVE(sig), .LOAD_SENSE(lsense),
      .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hro), .HRDATA(hrdata), .HREADYOUT(hro), .HRESP(hresp),
      .EQ_A(cfg[15:13]), .EQ_B(cfg[12:10]), .SWING_A(cfg[3:2]), .SWING_B(cfg[1:0]),
      .DEEMPH_A(cfg[9:7]), .DEEMPH_B(cfg[6:4]), .HALFBIT_A(cfg[17]), .HALFBIT_B(cfg[16]),
      .LOOPBACK_OUT_N(cfg[18]), .SIG_PRESENT_A0(sp_a), .SIG_PRESENT_B0(sp_b),
      .LOAD_PRESENT_A0(lp_a), .LOAD_PRESENT_B0(lp_b), .IN_TERM_50(in50),
      .OUT_DRIVE_50(drv50), .OUT_PULLUP_2K(pu2k));
   // ====
   // tasks
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer; read data is taken at the edge that ends the data phase
   task bus(input w, input [31:0] a, input [31:0] wd);
      @(posedge mclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge mclk);
      while (hro !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hro !== 1'b1) @(posedge mclk);
      rd = hrdata;
      @(negedge mclk);
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail = n_fail + 1;
         stop_test;
      end
   end
   // ====
   // tests
   initial begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (15) @(negedge mclk);
      chk(cfg, ST0);
      chk({lp_a, lp_b}, 2'h2);
      chk({in50, drv50, pu2k}, 24'h0F00FF);
      @(posedge mclk);
      st <= ~ST0;
      sig <= 8'h11;
      repeat (3) @(negedge mclk);
      chk(cfg, ST0);
      chk({sp_a, sp_b}, 2'h3);
      chk({in50, drv50, pu2k}, 24'h0F01FE);
      $display("test 1 done");
      bus(1'b1, 32'h20, 32'hFF);
      chk(cfg, ST0);
      bus(1'b0, 32'h20, 32'h0);
      chk(rd, 32'h6D);
      @(posedge mclk);
      sel <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         bus(1'b1, 32'h20, {i[2:0], i[1:0], i[2:0]});
         chk({cfg[9:7], cfg[3:2], cfg[15:13]}, {i[2:0], i[1:0], i[2:0]});
         chk({cfg[12:10], cfg[6:4], cfg[1:0]}, {ST0[12:10], ST0[6:4], ST0[1:0]});
         bus(1'b0, 32'h20, 32'h0);
         chk(rd, {i[2:0], i[1:0], i[2:0]});
      end
      bus(1'b1, 32'h08, 32'h0);
      chk(cfg[18:16], 3'h0);
      bus(1'b1, 32'h2C, 32'hFF);
      bus(1'b0, 32'h2C, 32'h0);
      chk(rd, 32'h0);
      @(posedge mclk);
      sel <= 1'b1;
      bus(1'b1, 32'h20, 32'h0);
      chk(cfg[15:13], 3'h7);
      $display("test 2 done");
      @(posedge mclk);
      crst_n <= 1'b0;
      mask <= 8'h10;
      repeat (3) @(negedge mclk);
      chk({lp_a, lp_b}, 2'h0);
      @(posedge mclk);
      crst_n <= 1'b1;
      repeat (10) @(negedge mclk);
      chk({lp_a, lp_b}, 2'h1);
      bus(1'b0, 32'h00, 32'h0);
      chk(rd, 32'h11);
      bus(1'b0, 32'h04, 32'h0);
      chk(rd, 32'h10);
      $display("test 3 done");
      @(posedge mclk);
      sel <= 1'b0;
      // detect enable is a captured strap, so bypass is reached through its register
      bus(1'b1, 32'h1C, 32'h2);
      @(posedge mclk);
      rxa <= 1'b0;
      repeat (4) @(negedge mclk);
      chk({in50[3:0], drv50[3:0], pu2k[3:0]}, 12'hF1E);
      @(posedge mclk);
      pd_n <= 1'b0;
      repeat (3) @(negedge mclk);
      chk({in50, drv50, pu2k}, 24'h0);
      $display("test 4 done");
      stop_test;
   end
endmodule // lcr_lane_cfg_rxdet_test

bind lcr_lane_cfg_rxdet lcr_checker #(.DETECT_CYCLES(DETECT_CYCLES)) lcr_checker_i (
   .MCLK(MCLK), .NRST(NRST), .CFG_PIN_SEL(CFG_PIN_SEL), .CHAN_RESET_N(CHAN_RESET_N),
   .POWER_DOWN_N(POWER_DOWN_N), .RXD_EN_A(RXD_EN_A), .RXD_EN_B(RXD_EN_B), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EQ_A(EQ_A),
   .SIG_ABOVE(SIG_ABOVE), .LOAD_SENSE(LOAD_SENSE), .SIG_PRESENT_A0(SIG_PRESENT_A0),
   .SIG_PRESENT_B0(SIG_PRESENT_B0), .LOAD_PRESENT_A0(LOAD_PRESENT_A0),
   .LOAD_PRESENT_B0(LOAD_PRESENT_B0), .IN_TERM_50(IN_TERM_50), .OUT_DRIVE_50(OUT_DRIVE_50),
   .OUT_PULLUP_2K(OUT_PULLUP_2K));
